// ===== hw/dbgev_core.sv
/*
 * Debug event detection: fixed events, instruction and data address compare,
 * sticky status and the control registers behind a plain strobe port.
 * Assumes pipeline inputs on the core clock; the unconditional pins are async.
 */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dbgev_core
    import dbgev_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    // Register port
    input  wire dbgev_bus_t        bus_in,
    output logic [31:0]            rd_data_out,
    // Pipeline side
    input  wire dbgev_pipe_t       pipe_in,
    input  wire logic              machine_state_debug_enable_in,
    // Unconditional requests
    input  wire logic              ext_uncond_event_in,
    input  wire logic              jtag_uncond_event_in,
    // Reporting
    output logic [ST_W-1:0]        debug_event_status_out,
    output logic                   debug_event_out,
    output logic                   trap_exc_suppress_out
);
    // Registers
    logic [C0_W-1:0] debug_control_zero_reg;
    logic [C0_W-1:0] debug_control_zero_next;
    logic [C1_W-1:0] debug_control_one_reg;
    logic [ST_W-1:0] debug_event_status_reg;
    logic [ST_W-1:0] debug_event_status_next;
    logic [31:0]     iac_reg [4];
    logic [31:0]     dac_reg [2];
    logic [31:0]     rd_data_reg;
    logic            event_reg;
    logic            trap_sup_reg;
    logic [1:0]      ext_sync_reg;
    logic [1:0]      jtag_sync_reg;
    logic            unc_prev_reg;

    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        logic [31:0] m;
        m = MSK_BYTE;
        unique case (sz)
            SZ_BYTE: m = MSK_BYTE;
            SZ_HALF: m = MSK_HALF;
            SZ_WORD: m = MSK_WORD;
            SZ_LINE: m = MSK_LINE;
        endcase
        return m;
    endfunction

    // Decode
    wire logic wr_c0  = bus_in.wr && bus_in.addr == OFF_CTRL0;
    wire logic wr_c1  = bus_in.wr && bus_in.addr == OFF_CTRL1;
    wire logic wr_st  = bus_in.wr && bus_in.addr == OFF_STATUS;
    wire logic wr_dac_a = bus_in.wr && bus_in.addr == OFF_DAC_A;
    wire logic wr_dac_b = bus_in.wr && bus_in.addr == OFF_DAC_B;

    // Control fields
    wire logic       internal_dbg_mode_en    = debug_control_zero_reg[C0_IDM];
    wire logic       external_dbg_mode_en    = debug_control_zero_reg[C0_EDM];
    wire logic       dwait  = debug_control_zero_reg[C0_WAIT];
    wire logic       de     = machine_state_debug_enable_in;
    wire logic [3:0] ia_en  = debug_control_zero_reg[C0_IA_EN +: 4];
    wire logic       ab_en  = debug_control_zero_reg[C0_AB_EN];
    wire logic       ab_x   = debug_control_zero_reg[C0_AB_X];
    wire logic       ab_t   = debug_control_zero_reg[C0_AB_T];
    wire logic       cd_en  = debug_control_zero_reg[C0_CD_EN];
    wire logic       cd_x   = debug_control_zero_reg[C0_CD_X];
    wire logic       cd_t   = debug_control_zero_reg[C0_CD_T];
    wire logic       rd_a   = debug_control_one_reg[C1_RD_A];
    wire logic       rd_b   = debug_control_one_reg[C1_RD_B];
    wire logic       wr_a   = debug_control_one_reg[C1_WR_A];
    wire logic       wr_b   = debug_control_one_reg[C1_WR_B];
    wire logic       d_rng  = debug_control_one_reg[C1_RANGE];
    wire logic       d_x    = debug_control_one_reg[C1_RANGE_X];
    wire logic [1:0] sz_a   = debug_control_one_reg[C1_SZ_A +: 2];
    wire logic [1:0] sz_b   = debug_control_one_reg[C1_SZ_B +: 2];

    // Internal-only mode with debug exceptions off
    wire logic quiet = internal_dbg_mode_en && !external_dbg_mode_en && !de;

    // Fixed events
    wire logic ev_ic   = pipe_in.instr_done && debug_control_zero_reg[C0_IC]
                         && !quiet;
    wire logic ev_bt   = pipe_in.branch_taken && debug_control_zero_reg[C0_BT]
                         && !quiet;
    wire logic ev_exc  = pipe_in.exc_valid && debug_control_zero_reg[C0_EXC]
                         && !(pipe_in.exc_critical && internal_dbg_mode_en && !external_dbg_mode_en);
    wire logic ev_trap = pipe_in.trap_satisfied
                         && debug_control_zero_reg[C0_TRAP];

    // Request arrives as a level; each rising edge is one event
    wire logic unc_lvl = ext_sync_reg[1] || jtag_sync_reg[1];
    wire logic ev_unc  = unc_lvl && !unc_prev_reg
                         && debug_control_zero_reg[C0_UNC];

    // Instruction address compare, word granular
    wire logic [31:0] ia_w = {pipe_in.ia_addr[31:2], 2'h0};
    logic [3:0] ia_exact;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_iex
            wire logic pair_rng = (gi < 2) ? ab_en : cd_en;
            assign ia_exact[gi] = pipe_in.ia_valid && ia_en[gi] && !pair_rng
                                  && ia_w == iac_reg[gi];
        end
    endgenerate

    logic ab_in;
    logic cd_in;
    dbgev_range_cmp u_rng_ab (
        .addr_in      (ia_w),
        .low_in       (iac_reg[0]),
        .high_in      (iac_reg[1]),
        .exclusive_in (ab_x),
        .hit_out      (ab_in)
    );
    dbgev_range_cmp u_rng_cd (
        .addr_in      (ia_w),
        .low_in       (iac_reg[2]),
        .high_in      (iac_reg[3]),
        .exclusive_in (cd_x),
        .hit_out      (cd_in)
    );

    // Toggle in internal-only mode with debug exceptions off would flip endlessly, so range is held off
    wire logic ab_act = ab_en && (ia_en[0] || ia_en[1]) && !(ab_t && quiet);
    wire logic cd_act = cd_en && (ia_en[2] || ia_en[3]) && !(cd_t && quiet);
    wire logic ab_hit = pipe_in.ia_valid && ab_act && ab_in;
    wire logic cd_hit = pipe_in.ia_valid && cd_act && cd_in;
    wire logic [3:0] ev_ia = ia_exact
                             | ({2'h0, ia_en[1:0]} & {4{ab_hit}})
                             | ({ia_en[3:2], 2'h0} & {4{cd_hit}});

    // Data address compare; one effective address per cycle
    wire logic [31:0] msk_a = size_mask(sz_a);
    wire logic [31:0] msk_b = size_mask(sz_b);
    wire logic da_ld = pipe_in.da_valid && !pipe_in.da_store;
    wire logic da_st = pipe_in.da_valid && pipe_in.da_store;
    wire logic any_d = rd_a || rd_b || wr_a || wr_b;
    wire logic ex_a  = !d_rng && (pipe_in.da_addr & msk_a) == (dac_reg[0] & msk_a);
    wire logic ex_b  = !d_rng && (pipe_in.da_addr & msk_b) == (dac_reg[1] & msk_b);

    logic d_in;
    dbgev_range_cmp u_rng_d (
        .addr_in      (pipe_in.da_addr),
        .low_in       (dac_reg[0]),
        .high_in      (dac_reg[1]),
        .exclusive_in (d_x),
        .hit_out      (d_in)
    );
    // Sizes not applied here: range compares the full address
    wire logic d_rhit = d_rng && any_d && d_in;
    wire logic ev_dr_a = da_ld && rd_a && (ex_a || d_rhit);
    wire logic ev_dw_a = da_st && wr_a && (ex_a || d_rhit);
    wire logic ev_dr_b = da_ld && rd_b && (ex_b || d_rhit);
    wire logic ev_dw_b = da_st && wr_b && (ex_b || d_rhit);

    // Event vector in status layout
    logic [ST_W-1:0] ev_set;
    always_comb begin
        ev_set          = STATUS_RST;
        ev_set[ST_IC]   = ev_ic;
        ev_set[ST_BT]   = ev_bt;
        ev_set[ST_EXC]  = ev_exc;
        ev_set[ST_TRAP] = ev_trap;
        ev_set[ST_UNC]  = ev_unc;
        ev_set[ST_IA_A] = ev_ia[0];
        ev_set[ST_IA_B] = ev_ia[1];
        ev_set[ST_IA_C] = ev_ia[2];
        ev_set[ST_IA_D] = ev_ia[3];
        ev_set[ST_DR_A] = ev_dr_a;
        ev_set[ST_DW_A] = ev_dw_a;
        ev_set[ST_DR_B] = ev_dr_b;
        ev_set[ST_DW_B] = ev_dw_b;
    end

    // Set wins over a clear in the same cycle
    wire logic [ST_W-1:0] clr = wr_st ? bus_in.wdata[ST_W-1:0] : STATUS_RST;
    assign debug_event_status_next = (debug_event_status_reg & ~clr) | ev_set;

    // Hardware toggle applied on top of any software write
    logic [C0_W-1:0] c0_base;
    always_comb begin
        c0_base = wr_c0 ? bus_in.wdata[C0_W-1:0] : debug_control_zero_reg;
        debug_control_zero_next = c0_base;
        debug_control_zero_next[C0_AB_X] = c0_base[C0_AB_X] ^ (ab_t && ab_hit);
        debug_control_zero_next[C0_CD_X] = c0_base[C0_CD_X] ^ (cd_t && cd_hit);
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = ADDR_RST;
        unique case (bus_in.addr)
            OFF_CTRL0:  rd_mux = {14'h0000, debug_control_zero_reg};
            OFF_CTRL1:  rd_mux = {22'h000000, debug_control_one_reg};
            OFF_STATUS: rd_mux = {18'h00000, debug_event_status_reg};
            OFF_IAC_A:  rd_mux = iac_reg[0];
            OFF_IAC_B:  rd_mux = iac_reg[1];
            OFF_IAC_C:  rd_mux = iac_reg[2];
            OFF_IAC_D:  rd_mux = iac_reg[3];
            OFF_DAC_A:  rd_mux = dac_reg[0];
            OFF_DAC_B:  rd_mux = dac_reg[1];
            default:    rd_mux = ADDR_RST;
        endcase
    end

    // Trap turned into a debug event instead of a program exception
    wire logic trap_sup_next = debug_control_zero_reg[C0_TRAP]
                               && (external_dbg_mode_en || (internal_dbg_mode_en && de) || dwait);

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            debug_control_zero_reg <= CTRL0_RST;
            debug_control_one_reg  <= CTRL1_RST;
            debug_event_status_reg <= STATUS_RST;
            rd_data_reg            <= ADDR_RST;
            event_reg              <= 1'b0;
            trap_sup_reg           <= 1'b0;
            ext_sync_reg           <= 2'h0;
            jtag_sync_reg          <= 2'h0;
            unc_prev_reg           <= 1'b0;
        end else if (ce_in) begin
            debug_control_zero_reg <= debug_control_zero_next;
            if (wr_c1) begin
                debug_control_one_reg <= bus_in.wdata[C1_W-1:0];
            end
            debug_event_status_reg <= debug_event_status_next;
            if (bus_in.rd) begin
                rd_data_reg <= rd_mux;
            end
            event_reg     <= |ev_set;
            trap_sup_reg  <= trap_sup_next;
            ext_sync_reg  <= {ext_sync_reg[0], ext_uncond_event_in};
            jtag_sync_reg <= {jtag_sync_reg[0], jtag_uncond_event_in};
            unc_prev_reg  <= unc_lvl;
        end
    end

    // Comparator address registers; instruction ones keep word bits only
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 4; i++) begin
                iac_reg[i] <= ADDR_RST;
            end
            dac_reg[0] <= ADDR_RST;
            dac_reg[1] <= ADDR_RST;
        end else if (ce_in) begin
            for (int i = 0; i < 4; i++) begin
                if (bus_in.wr && bus_in.addr == OFF_IAC_A + 8'(4 * i)) begin
                    iac_reg[i] <= {bus_in.wdata[31:2], 2'h0};
                end
            end
            if (wr_dac_a) begin
                dac_reg[0] <= bus_in.wdata;
            end
            if (wr_dac_b) begin
                dac_reg[1] <= bus_in.wdata;
            end
        end
    end

    assign rd_data_out            = rd_data_reg;
    assign debug_event_status_out = debug_event_status_reg;
    assign debug_event_out        = event_reg;
    assign trap_exc_suppress_out  = trap_sup_reg;

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_ab_hit;
        ce_in && ab_hit && ab_t && !wr_c0;
    endsequence
    sequence s_flipped;
        debug_control_zero_reg[C0_AB_X] != $past(debug_control_zero_reg[C0_AB_X]);
    endsequence

    property p_ic_set;
        ce_in && pipe_in.instr_done && debug_control_zero_reg[C0_IC] && !quiet
            |=> debug_event_status_reg[ST_IC] && debug_event_out;
    endproperty
    a_ic_set: assert property (p_ic_set) else $error("completion not recorded");

    property p_bt_quiet;
        quiet |-> !ev_set[ST_BT] && !ev_set[ST_IC];
    endproperty
    a_bt_quiet: assert property (p_bt_quiet) else $error("event not suppressed");

    property p_crit;
        pipe_in.exc_critical && internal_dbg_mode_en && !external_dbg_mode_en |-> !ev_set[ST_EXC];
    endproperty
    a_crit: assert property (p_crit) else $error("critical exception counted");

    property p_trap_sup;
        ce_in && debug_control_zero_reg[C0_TRAP] && external_dbg_mode_en |=> trap_exc_suppress_out;
    endproperty
    a_trap_sup: assert property (p_trap_sup) else $error("trap not suppressed");

    property p_toggle;
        s_ab_hit |=> s_flipped;
    endproperty
    a_toggle: assert property (p_toggle) else $error("exclusive bit not toggled");

    property p_no_exact;
        ab_en |-> !ia_exact[0] && !ia_exact[1];
    endproperty
    a_no_exact: assert property (p_no_exact) else $error("exact match in range mode");

    property p_quiet_range;
        ab_t && quiet |-> !ab_hit;
    endproperty
    a_quiet_range: assert property (p_quiet_range) else $error("range not disabled");

    property p_line;
        ce_in && da_ld && rd_a && !d_rng && sz_a == SZ_LINE
            && pipe_in.da_addr[31:5] == dac_reg[0][31:5]
            |=> debug_event_status_reg[ST_DR_A];
    endproperty
    a_line: assert property (p_line) else $error("line compare missed");

    property p_clear;
        ce_in && wr_st && bus_in.wdata[ST_TRAP] && !ev_set[ST_TRAP]
            |=> !debug_event_status_reg[ST_TRAP];
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_unc;
        ce_in && ext_sync_reg[1] && !unc_prev_reg && debug_control_zero_reg[C0_UNC]
            |=> debug_event_status_reg[ST_UNC];
    endproperty
    a_unc: assert property (p_unc) else $error("unconditional event lost");

    property p_incl;
        ce_in && da_st && wr_b && d_rng && !d_x
            && pipe_in.da_addr >= dac_reg[0] && pipe_in.da_addr < dac_reg[1]
            |=> debug_event_status_reg[ST_DW_B];
    endproperty
    a_incl: assert property (p_incl) else $error("range write missed");
endmodule

// ===== hw/dbgev_pkg.sv
/*
 * Constants, field layout and carrier types of the debug event compare block.
 * Assumes one core clock; register access over a plain strobe port.
 */
// Notes on behaviour
// - Completion event unless internal-only mode without enable.
// - Taken-branch event, same suppression as completion.
// - Exception event; critical ones dropped in internal-only mode.
// - Satisfied trap raises trap event.
// - Enabled trap events suppress trap program exception in external mode, wait mode or internal mode with enable.
// - External or port request raises unconditional event.
// - Four instruction comparators, each individually enabled.
// - Exact instruction match sets own status bit.
// - Pair a-b range hit sets enabled comparators.
// - Pair c-d range hit sets enabled comparators.
// - Range on disables exact matching for pair.
// - Inclusive range: low <= address < high.
// - Exclusive range: below low or at/above high.
// - Toggle bit flips exclusive bit per event.
// - Toggle in internal-only mode without enable disables pair range.
// - Data event on matching load or store.
// - Exact data hit sets read or write bit.
// - Each effective address checked on its own.
// - Size field masks 0, 1, 2 or 5 low bits.
// - Data range uses both comparators when enabled.
// - Size fields ignored during data range compare.
// - Status sticky; write one clears that bit.
package dbgev_pkg;

    localparam int unsigned AW = 8;

    // Register offsets
    localparam logic [AW-1:0] OFF_CTRL0  = 8'h00;
    localparam logic [AW-1:0] OFF_CTRL1  = 8'h04;
    localparam logic [AW-1:0] OFF_STATUS = 8'h08;
    localparam logic [AW-1:0] OFF_IAC_A  = 8'h0C;
    localparam logic [AW-1:0] OFF_IAC_B  = 8'h10;
    localparam logic [AW-1:0] OFF_IAC_C  = 8'h14;
    localparam logic [AW-1:0] OFF_IAC_D  = 8'h18;
    localparam logic [AW-1:0] OFF_DAC_A  = 8'h1C;
    localparam logic [AW-1:0] OFF_DAC_B  = 8'h20;

    // debug_control_zero fields
    localparam int unsigned C0_IDM     = 0;
    localparam int unsigned C0_EDM     = 1;
    localparam int unsigned C0_WAIT    = 2;
    localparam int unsigned C0_IC      = 3;
    localparam int unsigned C0_BT      = 4;
    localparam int unsigned C0_EXC     = 5;
    localparam int unsigned C0_TRAP    = 6;
    localparam int unsigned C0_UNC     = 7;
    localparam int unsigned C0_IA_EN   = 8;
    localparam int unsigned C0_AB_EN   = 12;
    localparam int unsigned C0_AB_X    = 13;
    localparam int unsigned C0_AB_T    = 14;
    localparam int unsigned C0_CD_EN   = 15;
    localparam int unsigned C0_CD_X    = 16;
    localparam int unsigned C0_CD_T    = 17;
    localparam int unsigned C0_W       = 18;

    // debug_control_one fields
    localparam int unsigned C1_RD_A    = 0;
    localparam int unsigned C1_RD_B    = 1;
    localparam int unsigned C1_WR_A    = 2;
    localparam int unsigned C1_WR_B    = 3;
    localparam int unsigned C1_RANGE   = 4;
    localparam int unsigned C1_RANGE_X = 5;
    localparam int unsigned C1_SZ_A    = 6;
    localparam int unsigned C1_SZ_B    = 8;
    localparam int unsigned C1_W       = 10;

    // debug_event_status fields
    localparam int unsigned ST_IC   = 0;
    localparam int unsigned ST_BT   = 1;
    localparam int unsigned ST_EXC  = 2;
    localparam int unsigned ST_TRAP = 3;
    localparam int unsigned ST_UNC  = 4;
    localparam int unsigned ST_IA_A = 5;
    localparam int unsigned ST_IA_B = 6;
    localparam int unsigned ST_DR_A = 7;
    localparam int unsigned ST_DW_A = 8;
    localparam int unsigned ST_DR_B = 9;
    localparam int unsigned ST_DW_B = 10;
    localparam int unsigned ST_IA_C = 12;
    localparam int unsigned ST_IA_D = 13;
    localparam int unsigned ST_W    = 14;

    // Reset values
    localparam logic [C0_W-1:0] CTRL0_RST  = 18'h00000;
    localparam logic [C1_W-1:0] CTRL1_RST  = 10'h000;
    localparam logic [ST_W-1:0] STATUS_RST = 14'h0000;
    localparam logic [31:0]     ADDR_RST   = 32'h00000000;

    // Compare size codes and masks
    localparam logic [1:0]  SZ_BYTE  = 2'h0;
    localparam logic [1:0]  SZ_HALF  = 2'h1;
    localparam logic [1:0]  SZ_WORD  = 2'h2;
    localparam logic [1:0]  SZ_LINE  = 2'h3;
    localparam logic [31:0] MSK_BYTE = 32'hFFFFFFFF;
    localparam logic [31:0] MSK_HALF = 32'hFFFFFFFE;
    localparam logic [31:0] MSK_WORD = 32'hFFFFFFFC;
    localparam logic [31:0] MSK_LINE = 32'hFFFFFFE0;

    // Pipeline view presented each core cycle
    typedef struct packed {
        logic        instr_done;
        logic        branch_taken;
        logic        exc_valid;
        logic        exc_critical;
        logic        trap_satisfied;
        logic        ia_valid;
        logic [31:0] ia_addr;
        logic        da_valid;
        logic        da_store;
        logic [31:0] da_addr;
    } dbgev_pipe_t;

    // Register port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [31:0]   wdata;
        logic          wr;
        logic          rd;
    } dbgev_bus_t;

endpackage

// ===== hw/dbgev_range_cmp.sv
/*
 * Address range comparator for one comparator pair.
 * Compares the addresses as given; the data range caller passes them unmasked.
 */
`timescale 1ns/1ps
module dbgev_range_cmp
    import dbgev_pkg::*;
(
    // Operands
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] low_in,
    input  wire logic [31:0] high_in,
    input  wire logic        exclusive_in,
    // Result
    output logic             hit_out
);
    wire logic ge_low  = addr_in >= low_in;
    wire logic lt_high = addr_in < high_in;
    wire logic incl    = ge_low && lt_high;
    wire logic excl    = !ge_low || !lt_high;

    assign hit_out = exclusive_in ? excl : incl;
endmodule

// ===== tb/dbgev_pipe_model.sv
/*
 * Execution pipeline and debug port model driving the debug event block.
 * Assumes the core clock; requests change just after a rising edge.
 */
`timescale 1ns/1ps
module dbgev_pipe_model
    import dbgev_pkg::*;
(
    // Clock
    input  wire logic  ref_clk_in,
    // Pipeline view and requests
    output dbgev_pipe_t pipe_out,
    output logic        ext_out,
    output logic        jtag_out
);
    initial begin
        pipe_out = '0;
        ext_out  = 1'b0;
        jtag_out = 1'b0;
    end

    // One-cycle strobe; idle addresses flip so stale values never match
    task automatic issue(input dbgev_pipe_t p);
        dbgev_pipe_t q;
        q = '0;
        q.ia_addr = ~p.ia_addr;
        q.da_addr = ~p.da_addr;
        @(posedge ref_clk_in);
        pipe_out <= p;
        @(posedge ref_clk_in);
        pipe_out <= q;
    endtask

    // Request level held long enough to pass the synchronisers
    task automatic uncond(input logic sel);
        @(posedge ref_clk_in);
        if (sel) begin
            jtag_out <= 1'b1;
        end else begin
            ext_out <= 1'b1;
        end
        repeat (4) @(posedge ref_clk_in);
        jtag_out <= 1'b0;
        ext_out  <= 1'b0;
    endtask
endmodule

// ===== tb/tb_top.sv
/*
 * Self-checking bench of the debug event block: register port tasks and
 * pipeline stimulus through the partner model. Assumes one 50 MHz clock.
 */
`timescale 1ns/1ps
module tb_top
    import dbgev_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            mse = 1'b1;
    logic            ce = 1'b1;
    dbgev_bus_t      bus = '0;
    dbgev_pipe_t     pipe;
    logic            ext, jtag, dev, sup;
    logic [31:0]     rdata;
    logic [ST_W-1:0] stat;
    int              failures = 0;
    int              checks = 0;

    always #10 clk = ~clk;

    dbgev_pipe_model pm (.ref_clk_in(clk), .pipe_out(pipe), .ext_out(ext), .jtag_out(jtag));
    dbgev_core dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .bus_in(bus),
        .rd_data_out(rdata), .pipe_in(pipe), .machine_state_debug_enable_in(mse),
        .ext_uncond_event_in(ext), .jtag_uncond_event_in(jtag),
        .debug_event_status_out(stat), .debug_event_out(dev), .trap_exc_suppress_out(sup));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stands from the cycle after the strobe until the next read
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk("read data", e, rdata);
    endtask

    function automatic dbgev_pipe_t mk(input logic [7:0] s, input logic [31:0] a);
        mk = '0;
        {mk.instr_done, mk.branch_taken, mk.exc_valid, mk.exc_critical, mk.trap_satisfied,
         mk.ia_valid, mk.da_valid, mk.da_store} = s;
        mk.ia_addr = a;
        mk.da_addr = a;
    endfunction

    task automatic ev(input logic [7:0] s, input logic [31:0] a, input logic [31:0] e);
        pm.issue(mk(s, a));
        rd_chk(OFF_STATUS, e);
        chk("status out", e, {18'h0, stat});
        wr(OFF_STATUS, 32'h00003FFF);
    endtask

    task automatic ic(input logic [31:0] c, input logic [31:0] a, input logic [31:0] e);
        wr(OFF_CTRL0, c);
        ev(8'h04, a, e);
    endtask

    task automatic dc(input logic [31:0] c, input logic [7:0] s, input logic [31:0] a,
                      input logic [31:0] e);
        wr(OFF_CTRL1, c);
        ev(s, a, e);
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(OFF_CTRL0, 32'h0);
        rd_chk(8'h24, 32'h0);
        wr(OFF_CTRL0, 32'h78);
        pm.issue(mk(8'h80, 0));
        @(negedge clk);
        chk("event pulse", 32'h1, {31'h0, dev});
        @(negedge clk);
        chk("event pulse", 32'h0, {31'h0, dev});
        ev(8'h80, 0, 32'h1);
        ev(8'h40, 0, 32'h2);
        ev(8'h30, 0, 32'h4);
        ev(8'h08, 0, 32'h8);
        pm.issue(mk(8'hC0, 0));
        wr(OFF_STATUS, 32'h1);
        ev(8'h00, 0, 32'h2);
        ce <= 1'b0;
        pm.issue(mk(8'h80, 0));
        ce <= 1'b1;
        ev(8'h00, 0, 32'h0);
        wr(OFF_CTRL0, 32'h79);
        mse <= 1'b0;
        ev(8'h80, 0, 32'h0);
        ev(8'h40, 0, 32'h0);
        ev(8'h30, 0, 32'h0);
        ev(8'h20, 0, 32'h4);
        chk("suppress", 32'h0, {31'h0, sup});
        wr(OFF_CTRL0, 32'h7B);
        rd_chk(OFF_CTRL0, 32'h7B);
        chk("suppress", 32'h1, {31'h0, sup});
        @(posedge clk) mse <= 1'b1;
        wr(OFF_IAC_A, 32'h100);
        wr(OFF_IAC_B, 32'h200);
        wr(OFF_IAC_C, 32'h300);
        wr(OFF_IAC_D, 32'h400);
        ic(32'h0100, 32'h100, 32'h20);
        ic(32'h0100, 32'h104, 32'h0);
        ic(32'h1300, 32'h200, 32'h0);
        ic(32'h1300, 32'h100, 32'h60);
        ic(32'h1300, 32'h1FC, 32'h60);
        ic(32'h3300, 32'h0FC, 32'h60);
        ic(32'h3300, 32'h100, 32'h0);
        ic(32'h3300, 32'h200, 32'h60);
        ic(32'h9400, 32'h300, 32'h1000);
        ic(32'h0800, 32'h400, 32'h2000);
        ic(32'h18400, 32'h2FC, 32'h1000);
        ic(32'h28400, 32'h300, 32'h1000);
        rd_chk(OFF_CTRL0, 32'h38400);
        ic(32'h5100, 32'h100, 32'h20);
        rd_chk(OFF_CTRL0, 32'h7100);
        @(posedge clk) mse <= 1'b0;
        ic(32'h5101, 32'h100, 32'h0);
        mse <= 1'b1;
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_DAC_A, 32'h1003);
        wr(OFF_DAC_B, 32'h2000);
        dc(32'h01, 8'h02, 32'h1003, 32'h80);
        dc(32'h01, 8'h03, 32'h1003, 32'h0);
        dc(32'h01, 8'h02, 32'h1002, 32'h0);
        dc(32'h41, 8'h02, 32'h1002, 32'h80);
        dc(32'h81, 8'h02, 32'h1000, 32'h80);
        dc(32'h81, 8'h02, 32'h1004, 32'h0);
        dc(32'hC1, 8'h02, 32'h101F, 32'h80);
        dc(32'hC1, 8'h02, 32'h1020, 32'h0);
        dc(32'h08, 8'h03, 32'h2000, 32'h400);
        dc(32'hD3, 8'h02, 32'h1001, 32'h0);
        dc(32'hD3, 8'h02, 32'h1003, 32'h280);
        dc(32'hF3, 8'h02, 32'h2000, 32'h280);
        dc(32'h18, 8'h03, 32'h1800, 32'h400);
        wr(OFF_CTRL0, 32'h80);
        pm.uncond(1'b0);
        ev(8'h00, 0, 32'h10);
        pm.uncond(1'b1);
        ev(8'h00, 0, 32'h10);
        tally_and_finish;
    end
endmodule
